// ---- rtl/rti_pkg.sv ----
// constants shared by the real-time clock two-wire target interface
package rti_pkg;
  // 7-bit target address 1101000, direction in bit 0
  localparam logic [6:0] TARGET_ADDR = 7'h68;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;    // bit index of the ninth clock
  localparam logic [3:0] LAST_DATA = 4'h7;   // bit index of the eighth clock
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] BIT_PRE = 4'hf;     // count parked between start and first scl fall
  localparam logic [7:0] PTR_STEP = 8'h01;
endpackage : rti_pkg

// ---- rtl/rti_sync.sv ----
// two-flop synchroniser with edge detection for the bus lines
`timescale 1ns/1ps
`default_nettype none
module rti_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;
  } rti_sync_t;
  rti_sync_t st_reg;
  rti_sync_t st_next;

  // idle lines rest high, so reset to ones to avoid a false edge
  always_comb begin
    st_next = st_reg;
    st_next.meta = async_in;
    st_next.stable = st_reg.meta;
    st_next.prev = st_reg.stable;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '{meta: '1, stable: '1, prev: '1};
    end else begin
      st_reg <= st_next;
    end
  end

  // edges are taken only from the second and third stages
  assign level = st_reg.stable;
  assign rise = st_reg.stable & ~st_reg.prev;
  assign fall = ~st_reg.stable & st_reg.prev;
endmodule // rti_sync
`default_nettype wire

// ---- rtl/rti_target.sv ----
// two-wire target interface of the real-time clock
`timescale 1ns/1ps
`default_nettype none
// Operation
// - idle bus lines are left released and rest high
// - lines are only pulled low or released, never driven high
// - sda falling while scl high is a start; expect an address byte
// - sda rising while scl high is a stop; return to idle
// - start before stop is a repeated start; expect a fresh address
// - transmitter changes sda while scl low; receiver samples on scl high
// - sda change during scl high is a condition, never a data bit
// - bytes are eight bits, msb first, unlimited count per transfer
// - register pointer advances after every data byte, read or write
// - receiver acknowledges each byte with a low bit
// - after eighth falling edge transmitter releases, receiver pulls low
// - controller acknowledging a read releases sda after ninth clock
// - no acknowledge ends a read; device releases sda and awaits stop
// - transfer opens with start plus address; respond only on match
// - target address 1101000, bit 0 direction, bytes d1h and d0h
module rti_target (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [7:0] reg_ptr,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  input wire logic [7:0] rd_data,
  output logic rd_strobe,
  output logic busy
);
  typedef enum logic [2:0] {
    RTI_IDLE, RTI_ADDR, RTI_PTR, RTI_WRITE, RTI_READ, RTI_WAIT_STOP
  } rti_state_t;

  typedef struct packed {
    rti_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic wstb;
    logic rstb;
    logic pull;
    logic reading;
    logic busy;
  } rti_target_t;

  rti_target_t st_reg;
  rti_target_t st_next;
  logic scl_lvl;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;
  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;
  logic start_cond;
  logic stop_cond;

  // bus pins come from another domain, so both pass two flip-flops
  rti_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({scl_in, sda_in}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  assign scl_lvl = lvl[1];
  assign sda_lvl = lvl[0];
  assign scl_rise = rise[1];
  assign scl_fall = fall[1];
  assign sda_rise = rise[0];
  assign sda_fall = fall[0];

  assign start_cond = sda_fall & scl_lvl & ~scl_rise;
  assign stop_cond = sda_rise & scl_lvl & ~scl_rise;

  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    return p + rti_pkg::PTR_STEP;
  endfunction

  // main sequencer, clocked by the system clock, stepping on scl edges
  always_comb begin
    st_next = st_reg;
    st_next.wstb = 1'b0;
    st_next.rstb = 1'b0;
    if (stop_cond) begin
      st_next.state = RTI_IDLE;
      st_next.pull = 1'b0;
      st_next.busy = 1'b0;
    end else if (start_cond) begin
      st_next.state = RTI_ADDR;
      // the scl fall that follows a start closes no bit, so park the count
      st_next.bit_cnt = rti_pkg::BIT_PRE;
      st_next.pull = 1'b0;
      st_next.busy = 1'b1;
    end else if (st_reg.state != RTI_IDLE && st_reg.state != RTI_WAIT_STOP) begin
      if (scl_rise) begin
        if (st_reg.bit_cnt == rti_pkg::ACK_SLOT) begin
          if (st_reg.state == RTI_READ && sda_lvl) begin
            st_next.state = RTI_WAIT_STOP;
          end
        end else if (st_reg.state != RTI_READ) begin
          // msb first; in read the register holds the outgoing byte instead
          st_next.shift = {st_reg.shift[6:0], sda_lvl};
        end
      end else if (scl_fall) begin
        // bits move only on scl falling, never on conditions
        if (st_reg.bit_cnt == rti_pkg::LAST_DATA) begin
          st_next.bit_cnt = rti_pkg::ACK_SLOT;
          st_next.pull = 1'b0;
          unique case (st_reg.state)
            RTI_ADDR: begin
              if (st_reg.shift[7:1] == rti_pkg::TARGET_ADDR) begin
                st_next.pull = 1'b1;
                st_next.reading = st_reg.shift[0];
              end else begin
                st_next.state = RTI_WAIT_STOP;
              end
            end
            RTI_PTR: begin
              st_next.ptr = st_reg.shift;
              st_next.pull = 1'b1;
            end
            RTI_WRITE: begin
              st_next.pull = 1'b1;
              st_next.wdata = st_reg.shift;
              st_next.wstb = 1'b1;
            end
            RTI_READ: begin
              st_next.ptr = ptr_inc(st_reg.ptr);
            end
            RTI_IDLE, RTI_WAIT_STOP: begin
              st_next.pull = 1'b0;
            end
          endcase
        end else if (st_reg.bit_cnt == rti_pkg::ACK_SLOT) begin
          st_next.bit_cnt = rti_pkg::BIT_ZERO;
          st_next.pull = 1'b0;
          unique case (st_reg.state)
            RTI_ADDR: begin
              st_next.state = st_reg.reading ? RTI_READ : RTI_PTR;
            end
            RTI_PTR: st_next.state = RTI_WRITE;
            RTI_WRITE: begin
              st_next.ptr = ptr_inc(st_reg.ptr);
            end
            RTI_READ, RTI_IDLE, RTI_WAIT_STOP: st_next.state = st_reg.state;
          endcase
          if (st_next.state == RTI_READ) begin
            st_next.shift = rd_data;
            st_next.rstb = 1'b1;
            st_next.pull = ~rd_data[7];
          end
        end else if (st_reg.bit_cnt == rti_pkg::BIT_PRE) begin
          // first fall after start opens the byte
          st_next.bit_cnt = rti_pkg::BIT_ZERO;
        end else begin
          st_next.bit_cnt = st_reg.bit_cnt + rti_pkg::BIT_ONE;
          if (st_reg.state == RTI_READ) begin
            st_next.pull = ~st_reg.shift[6];
            st_next.shift = {st_reg.shift[6:0], 1'b0};
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '{state: RTI_IDLE, bit_cnt: rti_pkg::BIT_ZERO,
                  shift: rti_pkg::BYTE_ZERO, ptr: rti_pkg::PTR_RESET,
                  wdata: rti_pkg::BYTE_ZERO, wstb: 1'b0, rstb: 1'b0,
                  pull: 1'b0, reading: 1'b0, busy: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // open drain: output fixed low, enable active low while pulling
  assign sda_out = 1'b0;
  assign sda_oe_n = ~st_reg.pull;
  assign reg_ptr = st_reg.ptr;
  assign wr_data = st_reg.wdata;
  assign wr_strobe = st_reg.wstb;
  assign rd_strobe = st_reg.rstb;
  assign busy = st_reg.busy;

  // sda stays released whenever the sequencer is in RTI_IDLE
  property p_idle_release;
    @(posedge clk) disable iff (sys_rst)
      st_reg.state == RTI_IDLE |-> sda_oe_n;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("sda pulled in idle");

  property p_stop_idle;
    @(posedge clk) disable iff (sys_rst)
      stop_cond |=> st_reg.state == RTI_IDLE && !busy;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

  property p_start_addr;
    @(posedge clk) disable iff (sys_rst)
      start_cond && !stop_cond |=> st_reg.state == RTI_ADDR && st_reg.bit_cnt == rti_pkg::BIT_PRE;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not honoured");

  property p_wr_inc;
    @(posedge clk) disable iff (sys_rst)
      st_reg.state == RTI_WRITE && scl_fall && st_reg.bit_cnt == rti_pkg::ACK_SLOT
      && !start_cond && !stop_cond |=> reg_ptr == $past(reg_ptr) + rti_pkg::PTR_STEP;
  endproperty
  a_wr_inc: assert property (p_wr_inc) else $error("pointer not advanced");

  property p_rd_inc;
    @(posedge clk) disable iff (sys_rst)
      st_reg.state == RTI_READ && scl_fall && st_reg.bit_cnt == rti_pkg::LAST_DATA
      && !start_cond && !stop_cond |=> reg_ptr == $past(reg_ptr) + rti_pkg::PTR_STEP;
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("pointer not advanced after read");

  property p_ptr_load;
    @(posedge clk) disable iff (sys_rst)
      st_reg.state == RTI_PTR && scl_fall && st_reg.bit_cnt == rti_pkg::LAST_DATA
      && !start_cond && !stop_cond |=> reg_ptr == $past(st_reg.shift) && !sda_oe_n;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer byte not taken");

  property p_write_ack;
    @(posedge clk) disable iff (sys_rst)
      st_reg.state == RTI_WRITE && scl_fall && st_reg.bit_cnt == rti_pkg::LAST_DATA
      && !start_cond && !stop_cond
      |=> wr_strobe && !sda_oe_n && wr_data == $past(st_reg.shift);
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("written byte not taken");

  property p_mismatch_silent;
    @(posedge clk) disable iff (sys_rst)
      st_reg.state == RTI_WAIT_STOP |-> sda_oe_n;
  endproperty
  a_mismatch_silent: assert property (p_mismatch_silent) else $error("drives when not addressed");

  property p_addr_ack;
    @(posedge clk) disable iff (sys_rst)
      st_reg.state == RTI_ADDR && scl_fall && st_reg.bit_cnt == rti_pkg::LAST_DATA
      && !start_cond && !stop_cond
      |=> sda_oe_n == ($past(st_reg.shift[7:1]) != rti_pkg::TARGET_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");

  property p_sda_change_low;
    @(posedge clk) disable iff (sys_rst)
      $changed(sda_oe_n) && $past(st_reg.state) != RTI_IDLE |-> !scl_lvl || !sda_oe_n == 1'b0
      || $past(scl_fall) || $past(start_cond) || $past(stop_cond);
  endproperty
  a_sda_change_low: assert property (p_sda_change_low) else $error("sda moved with scl high");

  property p_nack_release;
    @(posedge clk) disable iff (sys_rst)
      st_reg.state == RTI_READ && scl_rise && st_reg.bit_cnt == rti_pkg::ACK_SLOT && sda_lvl
      && !start_cond && !stop_cond |=> st_reg.state == RTI_WAIT_STOP ##1 sda_oe_n;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("nack not honoured");

  c_write: cover property (@(posedge clk) wr_strobe);
  c_read: cover property (@(posedge clk) rd_strobe);
  c_nack: cover property (@(posedge clk) st_reg.state == RTI_READ ##1 st_reg.state == RTI_WAIT_STOP);
  c_foreign: cover property (@(posedge clk)
    st_reg.state == RTI_ADDR ##1 st_reg.state == RTI_WAIT_STOP);
  c_restart: cover property (@(posedge clk) start_cond && st_reg.state == RTI_WRITE);
endmodule // rti_target
`default_nettype wire

// ---- tb/rti_ctl_model.sv ----
// bus controller model that drives the clock and data lines of the target
`timescale 1ns/1ps
`default_nettype none
module rti_ctl_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull
);
  // lines released at rest, only ever pulled low
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // start leaves the clock held low
  task automatic start();
    sda_pull <= 1'b1;
    wait_clk(4);
    scl_pull <= 1'b1;
  endtask
  // repeated start raised from a low clock
  task automatic restart();
    wait_clk(2);
    sda_pull <= 1'b0;
    wait_clk(2);
    scl_pull <= 1'b0;
    wait_clk(4);
    sda_pull <= 1'b1;
    wait_clk(4);
    scl_pull <= 1'b1;
  endtask
  // stop, then a long idle so the target settles
  task automatic stop();
    wait_clk(2);
    sda_pull <= 1'b1;
    wait_clk(2);
    scl_pull <= 1'b0;
    wait_clk(4);
    sda_pull <= 1'b0;
    wait_clk(6);
  endtask
  // data moves only while the clock is low
  task automatic bit_cycle(input logic b, output logic s);
    wait_clk(2);
    sda_pull <= ~b;
    wait_clk(2);
    scl_pull <= 1'b0;
    wait_clk(2);
    s = sda; // sampled mid-high, well clear of the target's edges
    wait_clk(2);
    scl_pull <= 1'b1;
  endtask
  // msb first, acknowledge read in the ninth slot
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], s);
    end
    bit_cycle(1'b1, ack);
  endtask
  // acknowledge to go on, withhold on the last byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(last, s);
    sda_pull <= 1'b0; // let go at the ninth falling edge
  endtask
endmodule // rti_ctl_model
`default_nettype wire

// ---- tb/tb_rti_target.sv ----
// self-checking bench for the two-wire target interface
`timescale 1ns/1ps
`default_nettype none
module tb_rti_target;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, sda, scl_pull, sda_pull, sda_out, sda_oe_n, wr_strobe, rd_strobe, busy, ack;
  logic [7:0] reg_ptr, wr_data, rd_data, b0, b1;
  logic [7:0] mem [256];
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  int wr_pulses = 0;
  int rd_pulses = 0;
  // row 0 leaves 11h at 00 for the simple read; the last row's reads wrap the pointer to zero
  localparam logic [23:0] ROWS [4] = '{24'h001122, 24'h10a55a, 24'h7eff00, 24'hfec33c};
  // wired-and with pull-up on both lines
  assign sda = ~(sda_pull | (~sda_oe_n & ~sda_out));
  assign scl = ~scl_pull;
  assign rd_data = mem[reg_ptr];
  always #10 clk = ~clk;
  rti_target dut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .reg_ptr(reg_ptr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_data(rd_data), .rd_strobe(rd_strobe), .busy(busy));
  rti_ctl_model ctl (.clk(clk), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull));
  // register file behind the write port; strobes are tallied for the count checks
  always @(posedge clk) begin
    if (wr_strobe === 1'b1) begin
      mem[reg_ptr] <= wr_data;
      wr_pulses <= wr_pulses + 1;
    end
    if (rd_strobe === 1'b1) begin
      rd_pulses <= rd_pulses + 1;
    end
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, far beyond the roughly 3200 cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("oe_n", 8'h01, {7'h00, sda_oe_n});
    chk("busy", 8'h00, {7'h00, busy});
    chk("ptr", 8'h00, reg_ptr);
    chk("sda_out", 8'h00, {7'h00, sda_out});
    foreach (ROWS[i]) begin
      ctl.start();
      ctl.wr_byte(8'hd0, ack);
      chk("addr_ack", 8'h00, {7'h00, ack});
      chk("busy", 8'h01, {7'h00, busy});
      ctl.wr_byte(ROWS[i][23:16], ack);
      chk("ptr_ack", 8'h00, {7'h00, ack});
      ctl.wr_byte(ROWS[i][15:8], ack);
      ctl.wr_byte(ROWS[i][7:0], ack);
      chk("data_ack", 8'h00, {7'h00, ack});
      ctl.stop();
      chk("busy", 8'h00, {7'h00, busy});
      ctl.start();
      ctl.wr_byte(8'hd0, ack);
      ctl.wr_byte(ROWS[i][23:16], ack);
      ctl.restart();
      ctl.wr_byte(8'hd1, ack);
      chk("rd_addr_ack", 8'h00, {7'h00, ack});
      ctl.rd_byte(1'b0, b0);
      ctl.rd_byte(1'b1, b1);
      ctl.stop();
      chk("rd0", ROWS[i][15:8], b0);
      chk("rd1", ROWS[i][7:0], b1);
      chk("ptr", ROWS[i][23:16] + 8'h02, reg_ptr);
    end
    // foreign address: no acknowledge and nothing taken
    ctl.start();
    ctl.wr_byte(8'ha0, ack);
    chk("foreign_ack", 8'h01, {7'h00, ack});
    ctl.wr_byte(8'h55, ack);
    chk("foreign_data_ack", 8'h01, {7'h00, ack});
    ctl.stop();
    chk("ptr", 8'h00, reg_ptr);
    // simplified read after the pointer wrapped to zero
    ctl.start();
    ctl.wr_byte(8'hd1, ack);
    ctl.rd_byte(1'b1, b0);
    ctl.stop();
    chk("simple_rd", 8'h11, b0);
    chk("ptr", 8'h01, reg_ptr);
    // two data bytes per row written; two loads per row read plus one simple read
    chk("wr_strobes", 8'h08, 8'(wr_pulses));
    chk("rd_strobes", 8'h09, 8'(rd_pulses));
    // reset in mid-transfer returns the target to rest
    ctl.start();
    ctl.wr_byte(8'hd0, ack);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("oe_n", 8'h01, {7'h00, sda_oe_n});
    chk("busy", 8'h00, {7'h00, busy});
    chk("ptr", 8'h00, reg_ptr);
    ctl.stop();
    stop_test();
  end
endmodule // tb_rti_target
`default_nettype wire
